// [verif/t1_framer_info_status_two_tb_top.sv]
// bench for the information status register two, with a bit-level flag model
module t1_framer_info_status_two_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, sys_rst = 1'b1, rd_strobe = 1'b0, rx_bit_valid = 1'b0, rx_zero = 1'b0;
	logic sync_loss_condition = 1'b1, carrier_loss_condition, all_ones_alarm;
	logic [7:0] rd_addr = 8'h00, rd_data, mf = 8'h00, last = 8'h00;
	info_status_pkg::event_s ev = '0;
	int err_total = 0, n_compared = 0, seed = 32'h7a10, i;
	// short window keeps the alarm scenario brief
	info_status_two #(.window_cycles(50)) DUT (.clk(clk), .sys_rst(sys_rst),
		.rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
		.rx_bit_valid(rx_bit_valid), .rx_zero(rx_zero), .sync_loss_condition(sync_loss_condition),
		.tx_store_full_event(ev.tx_store_full), .tx_store_empty_event(ev.tx_store_empty),
		.rx_density_event(ev.rx_density), .tx_density_event(ev.tx_density),
		.carrier_loss_condition(carrier_loss_condition), .all_ones_alarm(all_ones_alarm));
	always #5 clk = ~clk;
	task step;
		@(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one cycle: optional read plus event pulses; set wins over the clear of a read
	// the request stands until the next call, so back to back reads hold the strobe high with no gap between them
	task rd(input logic s, input logic [7:0] a, input logic [7:0] evb);
		logic [7:0] e, m;
		logic h;
		h = s && (a == info_status_pkg::info_two_offset);
		m = (evb & 8'h33) | (((evb & 8'h30) != 8'h00) ? 8'h08 : 8'h00);
		e = h ? mf : last;
		rd_strobe = s;
		rd_addr = a;
		ev = evb & 8'h33;
		step;
		chk("rd_data", e, rd_data);
		mf = h ? m : (mf | m);
		last = e;
	endtask
	task results;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under ten microseconds
	initial begin
		#50us;
		err_total++;
		results;
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		rd(1'b1, 8'h31, 8'h00);
		rd(1'b0, 8'h00, 8'h00);
		sync_loss_condition = 1'b0;
		repeat (3) step;
		mf[7] = 1'b1;
		rd(1'b1, 8'h31, 8'h00);
		rd(1'b1, 8'h31, 8'h00);
		rd(1'b0, 8'h00, 8'h00);
		rx_bit_valid = 1'b1;
		repeat (120) step;
		chk("all_ones_alarm", 8'h01, {7'h00, all_ones_alarm});
		rx_zero = 1'b1;
		repeat (191) step;
		chk("carrier_loss", 8'h00, {7'h00, carrier_loss_condition});
		step;
		chk("carrier_loss", 8'h01, {7'h00, carrier_loss_condition});
		chk("all_ones_alarm", 8'h00, {7'h00, all_ones_alarm});
		rx_zero = 1'b0;
		repeat (3) step;
		chk("carrier_loss", 8'h00, {7'h00, carrier_loss_condition});
		rx_bit_valid = 1'b0;
		mf = mf | 8'h44;
		rd(1'b1, 8'h31, 8'h00);
		// random events, reads and stray addresses; reads may be back to back
		for (i = 0; i < 60; i++) begin
			rd(1'($random(seed)), ($random(seed) & 1) ? 8'h31 : 8'($random(seed)), 8'($random(seed)));
		end
		rd(1'b1, 8'h31, 8'h00);
		rd(1'b1, 8'h31, 8'h00);
		results;
	end
endmodule // t1_framer_info_status_two_tb_top

// [verilog/info_status_pkg.sv]
// package: offsets, bit positions and constants of the information status register
package info_status_pkg;
	localparam logic [7:0] info_two_offset = 8'h31;
	localparam logic [7:0] info_two_reset = 8'h00;
	localparam int bit_sync_regained = 7;
	localparam int bit_carrier_restored = 6;
	localparam int bit_tx_store_full = 5;
	localparam int bit_tx_store_empty = 4;
	localparam int bit_tx_slip = 3;
	localparam int bit_blue_cleared = 2;
	localparam int bit_rx_density = 1;
	localparam int bit_tx_density = 0;
	localparam int carrier_loss_zeros = 192;
	localparam int blue_clear_zeros = 6;
	localparam int blue_window_us = 3000;
	localparam int clk_period_ns = 10;
	localparam int blue_window_cycles = (blue_window_us * 1000) / clk_period_ns;
	// detector events that feed the register, one bit per flag
	typedef struct packed {
		logic sync_regained;
		logic carrier_restored;
		logic tx_store_full;
		logic tx_store_empty;
		logic tx_slip;
		logic blue_cleared;
		logic rx_density;
		logic tx_density;
	} event_s;
endpackage

// [verilog/info_status_two.sv]
// per-framer information status register two with its condition detectors
// Function
// - An eight-bit register at 0x31 holds, msb first, sync regained, carrier restored, tx store full, tx store empty, tx slip, blue cleared, rx density and tx density.
// - Bit 7 sets when frame sync is attained and stays set until the register is read.
// - Bit 6 sets when carrier returns after a loss and stays set until read.
// - Bit 5 sets whenever the transmit elastic store fills and drops a frame.
// - Bit 4 sets whenever the transmit elastic store empties and repeats a frame.
// - Bit 3 sets whenever the transmit elastic store repeats or drops a frame.
// - Bit 2 sets when the all-ones alarm goes away and stays set until read.
// - Bit 1 sets when received data breaks the ones-density requirement.
// - Carrier loss is 192 consecutive received zeros; its end is the restore event.
// - The all-ones alarm clears when six or more zeros arrive within a 3 ms window.
module info_status_two #(
	parameter int window_cycles = info_status_pkg::blue_window_cycles
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rd_strobe,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic rx_bit_valid,
	input wire logic rx_zero,
	input wire logic sync_loss_condition,
	input wire logic tx_store_full_event,
	input wire logic tx_store_empty_event,
	input wire logic rx_density_event,
	input wire logic tx_density_event,
	output logic carrier_loss_condition,
	output logic all_ones_alarm
);
	// refuse a window too short for the counter to wrap
	if (window_cycles < 2) begin : g_bad_window
		$error("window_cycles too small");
	end

	info_status_pkg::event_s ev;
	logic [7:0] flags;
	logic hit;
	logic [7:0] zero_run;
	logic prev_sync_loss;
	logic prev_carrier_loss;
	logic prev_alarm;
	logic [31:0] win_count;
	logic [3:0] win_zeros;
	logic [3:0] zeros_now;

	assign hit = rd_strobe && (rd_addr == info_status_pkg::info_two_offset);

	// count consecutive received zeros, saturating at the loss threshold
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			zero_run <= 8'h00;
			carrier_loss_condition <= 1'b0;
		end else if (rx_bit_valid) begin
			if (!rx_zero) begin
				zero_run <= 8'h00;
				carrier_loss_condition <= 1'b0;
			end else if (zero_run < 8'(info_status_pkg::carrier_loss_zeros)) begin
				zero_run <= zero_run + 8'h01;
				if (zero_run == 8'(info_status_pkg::carrier_loss_zeros - 1)) begin
					carrier_loss_condition <= 1'b1;
				end
			end
		end
	end

	// zeros of the running window; a zero on its last cycle must count too
	assign zeros_now = (rx_bit_valid && rx_zero && win_zeros != 4'hf) ?
		win_zeros + 4'h1 : win_zeros;

	// window of fixed length; alarm decided on zeros seen at its end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			win_count <= 32'h0;
			win_zeros <= 4'h0;
			all_ones_alarm <= 1'b0;
		end else if (win_count == 32'(window_cycles - 1)) begin
			win_count <= 32'h0;
			win_zeros <= 4'h0;
			all_ones_alarm <= (zeros_now < 4'(info_status_pkg::blue_clear_zeros));
		end else begin
			win_count <= win_count + 32'h1;
			win_zeros <= zeros_now;
		end
	end

	// previous levels for falling-edge events
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_sync_loss <= 1'b1;
			prev_carrier_loss <= 1'b0;
			prev_alarm <= 1'b0;
		end else begin
			prev_sync_loss <= sync_loss_condition;
			prev_carrier_loss <= carrier_loss_condition;
			prev_alarm <= all_ones_alarm;
		end
	end

	// event map; slip is either store event
	always_comb begin
		ev.sync_regained = prev_sync_loss && !sync_loss_condition;
		ev.carrier_restored = prev_carrier_loss && !carrier_loss_condition;
		ev.tx_store_full = tx_store_full_event;
		ev.tx_store_empty = tx_store_empty_event;
		ev.tx_slip = tx_store_full_event || tx_store_empty_event;
		ev.blue_cleared = prev_alarm && !all_ones_alarm;
		ev.rx_density = rx_density_event;
		ev.tx_density = tx_density_event;
	end

	// one sticky cell per bit, packed order matches the register layout
	for (genvar i = 0; i < 8; i++) begin : g_flag
		sticky_bit u_bit (
			.clk(clk),
			.sys_rst(sys_rst),
			.set_pulse(ev[i]),
			.clear_pulse(hit),
			.flag(flags[i])
		);
	end

	// read data registered; value before the clear is returned
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= info_status_pkg::info_two_reset;
		end else if (hit) begin
			rd_data <= flags;
		end
	end

	// a read with no slip event in its cycle clears the slip flag
	chk_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
		hit && !ev[info_status_pkg::bit_tx_slip] |=> !flags[info_status_pkg::bit_tx_slip])
		else $error("slip flag survived a read");

	// a tx store full event is never lost, read or not
	chk_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
		ev.tx_store_full |=> flags[info_status_pkg::bit_tx_store_full])
		else $error("full event lost");

	// sync regained stays until a read
	chk_sticky_hold: assert property (@(posedge clk) disable iff (sys_rst)
		flags[info_status_pkg::bit_sync_regained] && !hit
		|=> flags[info_status_pkg::bit_sync_regained])
		else $error("sync flag dropped without read");

	// no flag of any kind drops without a read of this register
	chk_flags_kept: assert property (@(posedge clk) disable iff (sys_rst)
		!hit |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without read");

	// the end of sync loss raises the sync regained flag
	chk_sync_regain: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sync_loss_condition) |=> flags[info_status_pkg::bit_sync_regained])
		else $error("sync regain not flagged");

	// a full store raises full and slip together
	chk_full_sets: assert property (@(posedge clk) disable iff (sys_rst)
		tx_store_full_event
		|=> flags[info_status_pkg::bit_tx_store_full] && flags[info_status_pkg::bit_tx_slip])
		else $error("full did not set slip");

	// an empty store raises empty and slip together
	chk_slip_any: assert property (@(posedge clk) disable iff (sys_rst)
		tx_store_empty_event
		|=> flags[info_status_pkg::bit_tx_store_empty] && flags[info_status_pkg::bit_tx_slip])
		else $error("empty did not set slip");

	// carrier loss rises exactly on the last zero of the run
	chk_carrier_set: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(carrier_loss_condition)
		|-> $past(zero_run) == 8'(info_status_pkg::carrier_loss_zeros - 1))
		else $error("carrier loss at wrong count");

	// the loss level follows the saturated zero count
	chk_carrier_level: assert property (@(posedge clk) disable iff (sys_rst)
		carrier_loss_condition == (zero_run == 8'(info_status_pkg::carrier_loss_zeros)))
		else $error("carrier loss level out of step");

	// a received one ends the loss and restarts the count
	chk_carrier_clear: assert property (@(posedge clk) disable iff (sys_rst)
		rx_bit_valid && !rx_zero |=> !carrier_loss_condition && zero_run == 8'h00)
		else $error("carrier loss not cleared by a one");

	// the end of carrier loss raises the restore flag
	chk_carrier_back: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(carrier_loss_condition) |=> flags[info_status_pkg::bit_carrier_restored])
		else $error("carrier restore not flagged");

	// the end of the all-ones alarm raises the blue cleared flag
	chk_blue_back: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(all_ones_alarm) |=> flags[info_status_pkg::bit_blue_cleared])
		else $error("blue clear not flagged");

	// the alarm only moves at a window end
	chk_alarm_steady: assert property (@(posedge clk) disable iff (sys_rst)
		win_count != 32'(window_cycles - 1) |=> $stable(all_ones_alarm))
		else $error("alarm moved inside a window");

	// enough zeros in a window clear the alarm
	chk_alarm_clears: assert property (@(posedge clk) disable iff (sys_rst)
		win_count == 32'(window_cycles - 1) && zeros_now >= 4'(info_status_pkg::blue_clear_zeros)
		|=> !all_ones_alarm)
		else $error("alarm kept despite zeros");

	// a window with no zeros at all raises the alarm
	chk_alarm_sets: assert property (@(posedge clk) disable iff (sys_rst)
		win_count == 32'(window_cycles - 1) && zeros_now == 4'h0 |=> all_ones_alarm)
		else $error("alarm not raised on all ones");

	// the window counter never runs past its length
	chk_window_bound: assert property (@(posedge clk) disable iff (sys_rst)
		win_count < 32'(window_cycles))
		else $error("window counter overran");

	// both density events in one cycle land in both flags
	chk_density_set: assert property (@(posedge clk) disable iff (sys_rst)
		rx_density_event && tx_density_event
		|=> flags[info_status_pkg::bit_rx_density] && flags[info_status_pkg::bit_tx_density])
		else $error("density flags not set");

	// receive density violation alone
	chk_rx_density: assert property (@(posedge clk) disable iff (sys_rst)
		rx_density_event |=> flags[info_status_pkg::bit_rx_density])
		else $error("rx density flag not set");

	// transmit density violation alone
	chk_tx_density: assert property (@(posedge clk) disable iff (sys_rst)
		tx_density_event |=> flags[info_status_pkg::bit_tx_density])
		else $error("tx density flag not set");

	// a hit returns the flags as they stood before the clear
	chk_read_data: assert property (@(posedge clk) disable iff (sys_rst)
		hit |=> rd_data == $past(flags))
		else $error("read data mismatch");

	// other addresses leave the read data alone
	chk_miss_holds: assert property (@(posedge clk) disable iff (sys_rst)
		!hit |=> $stable(rd_data))
		else $error("read data moved without a hit");
endmodule // info_status_two

// [verilog/sticky_bit.sv]
// one sticky flag: set by an event, cleared by a register read, set wins
module sticky_bit (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic set_pulse,
	input wire logic clear_pulse,
	output logic flag
);
	// a set arriving with the clearing read is kept so no event is lost
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag <= 1'b0;
		end else if (set_pulse) begin
			flag <= 1'b1;
		end else if (clear_pulse) begin
			flag <= 1'b0;
		end
	end
endmodule // sticky_bit
